/* File: rtl/lane_decode_error_counters.sv */
// per-lane decode error counters with hold-enable and status registers
`timescale 1ns/10ps
module lane_decode_error_counters (
	input wire logic clk,
	input wire logic rstn,
	// lane control
	input wire logic deser_soft_reset,
	input wire logic [7:0] lane_enable,
	// decoded characters and error flags from the receive lanes
	input wire logic [7:0] char_valid,
	input wire logic [7:0] unexpected_control_char_error,
	input wire logic [7:0] code_missing_error,
	input wire logic [7:0] disparity_error,
	// register port
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// raw counter and flag view
	output logic [191:0] err_count,
	output logic [23:0] terminal_reached
);
	typedef struct packed {
		// hold-enable fields of lanes 6 and 7
		logic [2:0] hold6;
		logic [2:0] hold7;
		// registered lane activity
		logic [7:0] active;
		// read data and its strobe
		logic [7:0] rdata;
		logic rvalid;
	} lde_top_state_t;

	lde_top_state_t s_q;
	lde_top_state_t s_d;
	logic [7:0][2:0] hold_sel;
	logic [7:0][2:0] tcr;
	logic [7:0][23:0] cnt;
	logic [7:0][2:0] lane_err;
	logic [7:0] act_d;

	// decoded register hits and strobes
	logic hit_hold6;
	logic hit_hold7;
	logic hit_stat0;
	logic hit_stat1;
	logic wr_hold6;
	logic wr_hold7;

	// read bytes offered to the read select
	logic [7:0] hold6_byte;
	logic [7:0] hold7_byte;
	logic [7:0] stat0_byte;
	logic [7:0] stat1_byte;
	logic [7:0] rd_byte;

	// status byte: lane active at bit 3, terminal flags below
	function automatic logic [7:0] lde_status_byte(input logic act, input logic [2:0] flags);
		logic [7:0] b;
		b = lde_pkg::STATUS_RESET;
		b[lde_pkg::LANE_ACTIVE_BIT] = act;
		b[lde_pkg::ERR_FIELD_MSB:0] = flags;
		return b;
	endfunction : lde_status_byte

	// hold field in the low bits, reserved bits read zero
	function automatic logic [7:0] lde_hold_byte(input logic [2:0] h);
		logic [7:0] b;
		b = 8'h00;
		b[lde_pkg::ERR_FIELD_MSB:0] = h;
		return b;
	endfunction : lde_hold_byte

	// write data above the hold field is dropped
	function automatic logic [2:0] lde_hold_field(input logic [7:0] d);
		return d[lde_pkg::ERR_FIELD_MSB:0];
	endfunction : lde_hold_field

	// place the three error types at their field positions
	function automatic logic [2:0] lde_err_field(input logic ctrl, input logic miss, input logic disp);
		logic [2:0] f;
		f = 3'h0;
		f[lde_pkg::UNEXPECTED_CONTROL_CHAR_ERROR_BIT] = ctrl;
		f[lde_pkg::CODE_MISSING_ERROR_BIT] = miss;
		f[lde_pkg::DISPARITY_ERROR_BIT] = disp;
		return f;
	endfunction : lde_err_field

	function automatic logic lde_addr_hit(input logic [11:0] a, input logic [11:0] ofs);
		return a == ofs;
	endfunction : lde_addr_hit

	// a lane runs only while enabled and out of soft reset
	function automatic logic [7:0] lde_lane_run(input logic [7:0] ena, input logic srst);
		logic [7:0] r;
		r = 8'h00;
		if (!srst) begin
			r = ena;
		end
		return r;
	endfunction : lde_lane_run

	always_comb begin
		for (int l = 0; l < 8; l++) begin
			lane_err[l] = lde_err_field(unexpected_control_char_error[l], code_missing_error[l], disparity_error[l]);
		end
	end

	// lanes without a hold register keep the reset selection
	always_comb begin
		for (int l = 0; l < 6; l++) begin
			hold_sel[l] = lde_pkg::HOLD_ENABLE_RESET;
		end
		hold_sel[6] = s_q.hold6;
		hold_sel[7] = s_q.hold7;
	end

	// address decode shared by the write and read paths
	always_comb begin
		hit_hold6 = lde_addr_hit(reg_addr, lde_pkg::ERROR_HOLD_ENABLE_LANE6_OFS);
		hit_hold7 = lde_addr_hit(reg_addr, lde_pkg::ERROR_HOLD_ENABLE_LANE7_OFS);
		hit_stat0 = lde_addr_hit(reg_addr, lde_pkg::ERROR_STATUS_LANE0_OFS);
		hit_stat1 = lde_addr_hit(reg_addr, lde_pkg::ERROR_STATUS_LANE1_OFS);
		wr_hold6 = reg_wr && hit_hold6;
		wr_hold7 = reg_wr && hit_hold7;
	end

	// candidate read bytes from the current register state
	always_comb begin
		hold6_byte = lde_hold_byte(s_q.hold6);
		hold7_byte = lde_hold_byte(s_q.hold7);
		stat0_byte = lde_status_byte(s_q.active[0], tcr[0]);
		stat1_byte = lde_status_byte(s_q.active[1], tcr[1]);
	end

	// read select; unmapped addresses read zero
	always_comb begin
		unique case (1'b1)
			hit_hold6: begin
				rd_byte = hold6_byte;
			end
			hit_hold7: begin
				rd_byte = hold7_byte;
			end
			hit_stat0: begin
				rd_byte = stat0_byte;
			end
			hit_stat1: begin
				rd_byte = stat1_byte;
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// next activity, seen by the counters one cycle later
	always_comb begin
		act_d = lde_lane_run(lane_enable, deser_soft_reset);
	end

	always_comb begin
		s_d = s_q;
		s_d.rvalid = 1'b0;
		s_d.active = act_d;
		// writes expected while deserializer held in soft reset
		if (wr_hold6) begin
			s_d.hold6 = lde_hold_field(reg_wdata);
		end
		if (wr_hold7) begin
			s_d.hold7 = lde_hold_field(reg_wdata);
		end
		// read data stands until the next read
		if (reg_rd) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_byte;
		end
	end

	// reset loads the register reset values
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q.hold6 <= lde_pkg::HOLD_ENABLE_RESET;
			s_q.hold7 <= lde_pkg::HOLD_ENABLE_RESET;
			s_q.active <= 8'h00;
			s_q.rdata <= 8'h00;
			s_q.rvalid <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// three counters per lane, one per error type
	for (genvar l = 0; l < 8; l++) begin : g_lane
		lde_lane_counters u_cnt (
			.clk(clk),
			.rstn(rstn),
			.active(s_q.active[l]),
			.char_valid(char_valid[l]),
			.err(lane_err[l]),
			.hold(hold_sel[l]),
			.count(cnt[l]),
			.reached(tcr[l])
		);
	end

	// every output comes straight from a register
	assign reg_rdata = s_q.rdata;
	assign reg_rvalid = s_q.rvalid;
	assign err_count = cnt;
	assign terminal_reached = tcr;
endmodule : lane_decode_error_counters

/* File: rtl/lde_lane_counters.sv */
// three error counters and terminal flags of one receive lane
`timescale 1ns/10ps
module lde_lane_counters (
	input wire logic clk,
	input wire logic rstn,
	input wire logic active,
	input wire logic char_valid,
	input wire logic [2:0] err,
	input wire logic [2:0] hold,
	output logic [23:0] count,
	output logic [2:0] reached
);
	typedef struct packed {
		logic [2:0][7:0] cnt;
		logic [2:0] tcr;
	} lde_lane_state_t;

	lde_lane_state_t s_q;
	lde_lane_state_t s_d;

	always_comb begin
		s_d = s_q;
		for (int i = 0; i < 3; i++) begin
			if (!active) begin
				// counters and flags held cleared while the lane is disabled or in soft reset
				s_d.cnt[i] = lde_pkg::COUNT_RESET;
				s_d.tcr[i] = 1'b0;
			end else if (char_valid && err[i]) begin
				if (hold[i] && s_q.cnt[i] == lde_pkg::TERMINAL_COUNT) begin
					s_d.cnt[i] = s_q.cnt[i];
				end else begin
					// wrap past terminal, count one per error
					s_d.cnt[i] = 8'(s_q.cnt[i] + 8'h01);
				end
				if (s_d.cnt[i] == lde_pkg::TERMINAL_COUNT) begin
					s_d.tcr[i] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign count = s_q.cnt;
	assign reached = s_q.tcr;
endmodule : lde_lane_counters

/* File: rtl/lde_pkg.sv */
// shared constants for the lane decode error counters
package lde_pkg;
	localparam int unsigned NUM_LANES = 8;
	localparam int unsigned NUM_ERR = 3;
	localparam int unsigned CNT_W = 8;
	localparam int unsigned ADDR_W = 12;

	// register offsets
	localparam logic [11:0] ERROR_HOLD_ENABLE_LANE6_OFS = 12'h48e;
	localparam logic [11:0] ERROR_HOLD_ENABLE_LANE7_OFS = 12'h48f;
	localparam logic [11:0] ERROR_STATUS_LANE0_OFS = 12'h490;
	localparam logic [11:0] ERROR_STATUS_LANE1_OFS = 12'h491;

	// field positions within the error field and status byte
	localparam int unsigned UNEXPECTED_CONTROL_CHAR_ERROR_BIT = 2;
	localparam int unsigned CODE_MISSING_ERROR_BIT = 1;
	localparam int unsigned DISPARITY_ERROR_BIT = 0;
	localparam int unsigned LANE_ACTIVE_BIT = 3;
	localparam int unsigned ERR_FIELD_MSB = 2;

	// reset values and terminal count
	localparam logic [2:0] HOLD_ENABLE_RESET = 3'h7;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] TERMINAL_COUNT = 8'hff;
	localparam logic [7:0] COUNT_RESET = 8'h00;
endpackage : lde_pkg

/* File: test/lane_decode_error_counters_tb_top.sv */
// bench for the lane decode error counters
`timescale 1ns/10ps
module lane_decode_error_counters_tb_top;
	logic clk = 1'b0, rstn = 1'b0, sr = 1'b1, rd = 1'b0, wr = 1'b0, snd = 1'b0, rv;
	logic [7:0] en = 8'hff, wd = 8'h00, ln = 8'h00, cv, ue, cm, de, rdat;
	logic [11:0] ad = 12'h000;
	logic [2:0] kd = 3'h0;
	logic [191:0] cnt;
	logic [23:0] tr;
	int error_cnt = 0, compares = 0;
	lde_tx_model i_tx (.clk, .send(snd), .lanes(ln), .kind(kd), .cv, .ue, .cm, .de);
	lane_decode_error_counters i_dut (.clk, .rstn, .deser_soft_reset(sr), .lane_enable(en), .char_valid(cv),
		.unexpected_control_char_error(ue), .code_missing_error(cm), .disparity_error(de), .reg_addr(ad), .reg_wr(wr),
		.reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdat), .reg_rvalid(rv), .err_count(cnt), .terminal_reached(tr));
	initial forever #5 clk = ~clk;
	task chk(input string n, input logic [23:0] s, e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s exp %h got %h", n, e, s);
		end
	endtask : chk
	// one register access; reads compare valid and data
	task rg(input logic [11:0] a, input logic w, input logic [7:0] e);
		@(posedge clk) begin
			ad <= a;
			wd <= e;
			wr <= w;
			rd <= !w;
		end
		@(posedge clk) begin
			wr <= 1'b0;
			rd <= 1'b0;
		end
		#1 if (!w) chk("rdata", {rv, rdat}, {1'b1, e});
	endtask : rg
	task tx(input logic [7:0] l, input logic [2:0] k, input int n);
		@(posedge clk) begin
			ln <= l;
			kd <= k;
			snd <= 1'b1;
		end
		repeat (n) @(posedge clk);
		snd <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : tx
	task t_reset;
		rg(12'h48e, 0, 8'h07);
		rg(12'h4a0, 0, 8'h00);
		rg(12'h490, 0, 8'h00);
		rg(12'h48f, 0, 8'h07);
		rg(12'h48f, 1, 8'h00);
		rg(12'h48f, 0, 8'h00);
		rg(12'h48e, 1, 8'hfd);
		rg(12'h48e, 0, 8'h05);
		$display("reset test done");
	endtask : t_reset
	task t_hold;
		@(posedge clk) sr <= 1'b0;
		repeat (2) @(posedge clk);
		rg(12'h490, 0, 8'h08);
		tx(8'h81, 3'h1, 256);
		chk("hold", cnt[7:0], 8'hff);
		chk("wrap", cnt[175:168], 8'h00);
		chk("flags", {tr[21], tr[0]}, 2'h3);
		chk("others", cnt[23:8], 16'h0000);
		rg(12'h490, 0, 8'h09);
		$display("hold test done");
	endtask : t_hold
	task t_step;
		tx(8'h03, 3'h6, 3);
		chk("lane1", cnt[47:24], 24'h030300);
		chk("lane0", cnt[23:0], 24'h0303ff);
		rg(12'h491, 0, 8'h08);
		@(posedge clk) sr <= 1'b1;
		repeat (3) @(posedge clk);
		chk("clear", cnt[23:0], 24'h000000);
		chk("flags clear", tr, 24'h000000);
		rg(12'h490, 0, 8'h00);
		$display("step test done");
	endtask : t_step
	task summarize;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_hold;
		t_step;
		summarize;
	end
	initial begin
		#20000;
		error_cnt++;
		summarize;
	end
endmodule : lane_decode_error_counters_tb_top

/* File: test/lde_asserts.sv */
// port checker for lane 0 counters and status
`timescale 1ns/10ps
module lde_asserts (
	input wire logic clk,
	input wire logic rstn,
	input wire logic deser_soft_reset,
	input wire logic [7:0] lane_enable,
	input wire logic [7:0] char_valid,
	input wire logic [7:0] code_missing_error,
	input wire logic [7:0] disparity_error,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic [191:0] err_count,
	input wire logic [23:0] terminal_reached
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire on0 = lane_enable[0] && !deser_soft_reset;
	AST_STEP: assert property (char_valid[0] && disparity_error[0] && $past(on0 && rstn) && err_count[7:0] != 8'hff
		|=> err_count[7:0] == $past(err_count[7:0]) + 8'h01) else $error("count no step");
	AST_HOLD: assert property (err_count[7:0] == 8'hff && $past(on0)
		|=> err_count[7:0] == 8'hff) else $error("count left terminal");
	AST_FLAG: assert property (err_count[7:0] == 8'hff |-> terminal_reached[0]) else $error("flag low");
	AST_SPLIT: assert property ($changed(err_count[15:8]) && err_count[15:8] != 8'h00
		|-> $past(char_valid[0] && code_missing_error[0])) else $error("wrong counter");
	AST_STAT: assert property (reg_rvalid && $past(reg_addr) == 12'h490 && $past(rstn, 2)
		|-> reg_rdata[3] == $past(on0, 2)) else $error("status bit wrong");
	AST_CLR: assert property (!$past(on0, 2) && $past(rstn, 2)
		|-> err_count[7:0] == 8'h00 && !terminal_reached[0]) else $error("count not cleared");
endmodule : lde_asserts
bind lane_decode_error_counters lde_asserts i_chk (.clk, .rstn, .deser_soft_reset, .lane_enable, .char_valid,
	.code_missing_error, .disparity_error, .reg_addr, .reg_rdata, .reg_rvalid, .err_count, .terminal_reached);

/* File: test/lde_tx_model.sv */
// far-end transmitter model sending errored characters
`timescale 1ns/10ps
module lde_tx_model (
	input wire logic clk,
	input wire logic send,
	input wire logic [7:0] lanes,
	input wire logic [2:0] kind,
	output logic [7:0] cv,
	output logic [7:0] ue,
	output logic [7:0] cm,
	output logic [7:0] de
);
	initial {cv, ue, cm, de} = '0;
	// idle error lines flip so stale values never look valid
	always @(posedge clk) begin
		cv <= send ? lanes : 8'h00;
		{ue, cm, de} <= send ? {{8{kind[2]}} & lanes, {8{kind[1]}} & lanes, {8{kind[0]}} & lanes} : ~{ue, cm, de};
	end
endmodule : lde_tx_model
